// file: dcwm_host_model.sv
// Purpose: host controller model, writes the control word over apb
// Assumes: the slave may add wait states; pready sampled at rising edges
// Notes:   released write data shows the inverse of the last value
`default_nettype none
module dcwm_host_model
    import dcwm_pkg::*;
(
    // clock
    input  wire logic        pclk,
    // apb request
    output var logic         psel,
    output var logic         penable,
    output var logic         pwrite,
    output var logic [7:0]   paddr,
    output var logic [31:0]  pwdata,
    // apb answer
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_err;

    initial begin
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        last_err = 1'b0;
    end

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask

    // ----------------------------------------
    // control word helpers
    // ----------------------------------------
    task automatic write_cword(input logic [14:0] cw);
        wr(DCWM_OFF_CWORD, {17'h0_0000, cw & DCWM_CWORD_MASK});
    endtask

    task automatic service_wdog(input logic [14:0] cw);
        write_cword(cw & ~15'h4000);
        write_cword(cw | 15'h4000);
    endtask
endmodule // dcwm_host_model
`default_nettype wire

// file: dcwm_mapper.sv
// Purpose: event flags, control word, gate and sequencer input selection
// Assumes: APB slave on pclk, one wait-free access phase
// Notes:   inputs from the drive are synchronised before use
`default_nettype none
// Summary of operation
// - defaults-loaded-and-saved event sets event flag bit 0.
// - mode-changed-and-saved event sets event flag bit 1.
// - event flags are sticky, cleared only by power-up reset.
// - gate zero: control word has no effect on anything.
// - gate one: control word bits may drive sequencer and functions.
// - bits 0..9 map enable, runs, jog, direction, not-stop, auto, reference, jog reverse.
// - bits 10,11 reserved; 12 trip, 13 reset, 14 keypad watchdog.
// - bits 0-6,9 override parameters only when gated and auto bit set.
// - bit 12 trips drive when gated; trip holds until bit or gate clears.
// - gated rising edge of bit 13 resets drive; reset parameter untouched.
// - gated rising edge of bit 14 arms/services watchdog; timeout trips and disarms.
module dcwm_mapper
    import dcwm_pkg::*;
#(
    parameter int unsigned WDOG_CYC = DCWM_WDOG_CYC,
    parameter int unsigned SCAN_CYC = DCWM_SCAN_CYC
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // drive events (asynchronous levels, pulses by edge)
    input  wire logic        defaults_saved,
    input  wire logic        mode_change_saved,
    // sequencer inputs
    output logic             seq_drive_enable,
    output logic             seq_run_forward,
    output logic             seq_jog,
    output logic             seq_run_reverse,
    output logic             seq_direction_select,
    output logic             seq_run,
    output logic             seq_not_stop,
    output logic             seq_jog_reverse,
    output logic             reference_select,
    // drive functions
    output logic             control_word_trip,
    output logic             comms_loss_trip,
    output logic             drive_reset_pulse,
    output logic             scan_tick,
    // interrupt
    output logic             irq
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] ev_meta_reg;
    logic [1:0] ev_sync_reg;
    logic [1:0] ev_prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_meta_reg <= 2'h0;
            ev_sync_reg <= 2'h0;
            ev_prev_reg <= 2'h0;
        end else begin
            ev_meta_reg <= {mode_change_saved, defaults_saved};
            ev_sync_reg <= ev_meta_reg;
            ev_prev_reg <= ev_sync_reg;
        end
    end
    wire logic [1:0] ev_rise = ev_sync_reg & ~ev_prev_reg;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire logic acc      = psel && penable;
    wire logic wr_acc   = acc && pwrite;
    wire logic hit_flag = (paddr == DCWM_OFF_FLAGS);
    wire logic hit_cw   = (paddr == DCWM_OFF_CWORD);
    wire logic hit_gate = (paddr == DCWM_OFF_GATE);
    wire logic hit_ist  = (paddr == DCWM_OFF_IRQ_ST);
    wire logic hit_ien  = (paddr == DCWM_OFF_IRQ_EN);
    wire logic hit_icl  = (paddr == DCWM_OFF_IRQ_CL);
    wire logic hit_par  = (paddr == DCWM_OFF_PARAM);
    wire logic hit_stat = (paddr == DCWM_OFF_STAT);
    wire logic hit_scan = (paddr == DCWM_OFF_SCAN);
    wire logic hit_any  = hit_flag | hit_cw | hit_gate | hit_ist | hit_ien
                        | hit_icl | hit_par | hit_stat | hit_scan;
    wire logic wr_cw    = wr_acc && hit_cw;
    wire logic wr_gate  = wr_acc && hit_gate;
    wire logic wr_ien   = wr_acc && hit_ien;
    wire logic wr_icl   = wr_acc && hit_icl;
    wire logic wr_par   = wr_acc && hit_par;
    assign pready  = 1'b1;
    assign pslverr = acc && !hit_any;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] drive_event_flags_reg;
    logic [14:0] sequencer_control_word_reg;
    logic        control_word_gate_reg;
    logic [9:0]  param_reg;
    logic [3:0]  irq_st_reg;
    logic [3:0]  irq_en_reg;
    logic [31:0] prdata_reg;
    logic [15:0] flags_next;
    logic [3:0]  irq_st_next;

    // only set paths exist, so the flags can only clear at reset
    assign flags_next = drive_event_flags_reg | {14'h0000, ev_rise};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_event_flags_reg <= DCWM_FLAGS_RST;
        end else begin
            drive_event_flags_reg <= flags_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sequencer_control_word_reg <= DCWM_CWORD_RST;
            control_word_gate_reg      <= 1'b0;
            param_reg                  <= DCWM_PARAM_RST;
            irq_en_reg                 <= 4'h0;
        end else begin
            if (wr_cw) begin
                sequencer_control_word_reg <= pwdata[14:0] & DCWM_CWORD_MASK;
            end
            if (wr_gate) begin
                control_word_gate_reg <= pwdata[0];
            end
            if (wr_par) begin
                param_reg <= pwdata[9:0];
            end
            if (wr_ien) begin
                irq_en_reg <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------
    // control word mapping
    // ----------------------------------------
    wire logic [14:0] cw      = sequencer_control_word_reg;
    wire logic        gated   = control_word_gate_reg;
    wire logic        seq_ovr = gated && cw[DCWM_B_AUTO];
    logic [9:0]       seq_sel;
    logic [9:0]       seq_reg;
    assign seq_sel = seq_ovr ? cw[9:0] : param_reg;

    logic             ref_reg;
    logic             ref_next;
    assign ref_next = gated ? cw[DCWM_B_REF_SEL] : param_reg[DCWM_B_REF_SEL];

    // sequencer sees the selection once per scan
    logic [31:0] scan_cnt_reg;
    logic        scan_tick_reg;
    wire logic   scan_end = (scan_cnt_reg >= SCAN_CYC - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt_reg  <= 32'h0000_0000;
            scan_tick_reg <= 1'b0;
            seq_reg       <= DCWM_PARAM_RST;
            ref_reg       <= 1'b0;
        end else begin
            scan_cnt_reg  <= scan_end ? 32'h0000_0000 : scan_cnt_reg + 32'h0000_0001;
            scan_tick_reg <= scan_end;
            ref_reg       <= ref_next;
            if (scan_end) begin
                seq_reg <= seq_sel;
            end
        end
    end
    assign seq_drive_enable     = seq_reg[DCWM_B_ENABLE];
    assign seq_run_forward      = seq_reg[DCWM_B_RUN_FWD];
    assign seq_jog              = seq_reg[DCWM_B_JOG];
    assign seq_run_reverse      = seq_reg[DCWM_B_RUN_REV];
    assign seq_direction_select = seq_reg[DCWM_B_FWD_REV];
    assign seq_run              = seq_reg[DCWM_B_RUN];
    assign seq_not_stop         = seq_reg[DCWM_B_NOT_STOP];
    assign seq_jog_reverse      = seq_reg[DCWM_B_JOG_REV];
    assign reference_select     = ref_reg;
    assign scan_tick            = scan_tick_reg;

    // ----------------------------------------
    // trip, reset and watchdog
    // ----------------------------------------
    logic trip_reg;
    logic rst_prev_reg;
    logic wd_prev_reg;
    logic reset_pulse_reg;
    logic cl_trip_reg;
    wire logic rst_bit  = gated && cw[DCWM_B_RESET];
    wire logic wd_bit   = gated && cw[DCWM_B_WDOG];
    wire logic rst_rise = rst_bit && !rst_prev_reg;
    wire logic wd_rise  = wd_bit && !wd_prev_reg;
    wire logic wd_expire;
    wire logic wd_armed;

    dcwm_wdog #(
        .TIMEOUT_CYC (WDOG_CYC)
    ) u_wdog (
        .pclk    (pclk),
        .presetn (presetn),
        .service (wd_rise),
        .armed   (wd_armed),
        .expire  (wd_expire)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_reg        <= 1'b0;
            rst_prev_reg    <= 1'b0;
            wd_prev_reg     <= 1'b0;
            reset_pulse_reg <= 1'b0;
            cl_trip_reg     <= 1'b0;
        end else begin
            rst_prev_reg    <= rst_bit;
            wd_prev_reg     <= wd_bit;
            reset_pulse_reg <= rst_rise;
            // trip stays while bit 12 is set; a drive reset cannot clear it
            trip_reg        <= gated && cw[DCWM_B_TRIP];
            if (wd_expire) begin
                cl_trip_reg <= 1'b1;
            end else if (rst_rise) begin
                cl_trip_reg <= 1'b0;
            end
        end
    end
    assign control_word_trip = trip_reg;
    assign drive_reset_pulse = reset_pulse_reg;
    assign comms_loss_trip   = cl_trip_reg;

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // bit 2 marks only the cycle in which the control word trip starts
    wire logic       trip_rise = gated && cw[DCWM_B_TRIP] && !trip_reg;
    wire logic [3:0] irq_ev    = {wd_expire, trip_rise, ev_rise};
    // set wins over a clear in the same cycle
    assign irq_st_next = (irq_st_reg & ~({4{wr_icl}} & pwdata[3:0])) | irq_ev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_reg <= 4'h0;
        end else begin
            irq_st_reg <= irq_st_next;
        end
    end
    assign irq = |(irq_st_reg & irq_en_reg);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire logic [31:0] stat_word = {26'h000_0000, wd_armed, cl_trip_reg, trip_reg,
                                   seq_ovr, gated, reset_pulse_reg};
    wire logic [31:0] rd_mux =
          hit_flag ? {16'h0000, drive_event_flags_reg}
        : hit_cw   ? {17'h0_0000, sequencer_control_word_reg}
        : hit_gate ? {31'h0000_0000, control_word_gate_reg}
        : hit_ist  ? {28'h000_0000, irq_st_reg}
        : hit_ien  ? {28'h000_0000, irq_en_reg}
        : hit_par  ? {22'h00_0000, param_reg}
        : hit_stat ? stat_word
        : hit_scan ? scan_cnt_reg
        : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end
    assign prdata = prdata_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_flag_defaults: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ev_sync_reg[0]) |=> drive_event_flags_reg[DCWM_F_DEFAULTS])
        else $error("defaults flag not set");
    chk_flag_mode: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ev_sync_reg[1]) |=> drive_event_flags_reg[DCWM_F_MODE])
        else $error("mode flag not set");

    chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        drive_event_flags_reg[1:0] != 2'h0 |=> ($past(drive_event_flags_reg[1:0])
        & ~drive_event_flags_reg[1:0]) == 2'h0) else $error("event flag cleared");

    chk_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !gated |=> !trip_reg && !reset_pulse_reg) else $error("control word acted ungated");

    chk_ovr_map: assert property (@(posedge pclk) disable iff (!presetn)
        scan_end && seq_ovr |=> seq_reg == $past(cw[9:0])) else $error("override not taken");
    chk_param_keep: assert property (@(posedge pclk) disable iff (!presetn)
        scan_end && !seq_ovr |=> seq_reg == $past(param_reg)) else $error("params lost control");
    chk_scan_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !scan_end |=> $stable(seq_reg))
        else $error("sequencer inputs moved mid scan");
    // bit 8 follows the gate alone, the auto bit has no say in it
    chk_ref_gated: assert property (@(posedge pclk) disable iff (!presetn)
        gated |=> ref_reg == $past(cw[DCWM_B_REF_SEL]))
        else $error("reference not taken from word");

    chk_trip_hold: assert property (@(posedge pclk) disable iff (!presetn)
        gated && cw[DCWM_B_TRIP] |=> trip_reg) else $error("trip not held");
    chk_trip_release: assert property (@(posedge pclk) disable iff (!presetn)
        !(gated && cw[DCWM_B_TRIP]) |=> !trip_reg)
        else $error("trip outlived its bit");

    chk_reset_edge: assert property (@(posedge pclk) disable iff (!presetn)
        rst_rise |=> reset_pulse_reg ##1 !reset_pulse_reg) else $error("reset pulse wrong");
    chk_reset_gated: assert property (@(posedge pclk) disable iff (!presetn)
        reset_pulse_reg |-> $past(gated))
        else $error("reset pulse without gate");

    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cw[11:10] == 2'h0) else $error("reserved bits stored");
    chk_wdog_trip: assert property (@(posedge pclk) disable iff (!presetn)
        wd_expire |=> comms_loss_trip && !wd_armed) else $error("no comms loss trip");
    chk_loss_keep: assert property (@(posedge pclk) disable iff (!presetn)
        comms_loss_trip && !wd_expire && !rst_rise |=> comms_loss_trip)
        else $error("comms loss trip dropped");
    chk_loss_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(comms_loss_trip) |-> $past(wd_expire))
        else $error("comms loss trip unprompted");

    cov_override: cover property (@(posedge pclk) seq_ovr && scan_end);
    cov_trip: cover property (@(posedge pclk) $rose(trip_reg));
    cov_reset: cover property (@(posedge pclk) rst_rise);
    cov_wdog_expire: cover property (@(posedge pclk) wd_expire);
    cov_mode_flag: cover property (@(posedge pclk) $rose(drive_event_flags_reg[DCWM_F_MODE]));
endmodule // dcwm_mapper
`default_nettype wire

// file: dcwm_pkg.sv
// Purpose: constants and types shared by the drive control word mapper
// Assumes: 32-bit APB, 100 MHz pclk
// Notes:   offsets are byte addresses of aligned words
`default_nettype none
package dcwm_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] DCWM_OFF_FLAGS  = 8'h00;
    localparam logic [7:0] DCWM_OFF_CWORD  = 8'h04;
    localparam logic [7:0] DCWM_OFF_GATE   = 8'h08;
    localparam logic [7:0] DCWM_OFF_IRQ_ST = 8'h0C;
    localparam logic [7:0] DCWM_OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] DCWM_OFF_IRQ_CL = 8'h14;
    localparam logic [7:0] DCWM_OFF_PARAM  = 8'h18;
    localparam logic [7:0] DCWM_OFF_STAT   = 8'h1C;
    localparam logic [7:0] DCWM_OFF_SCAN   = 8'h20;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [14:0] DCWM_CWORD_RST = 15'h0000;
    localparam logic [15:0] DCWM_FLAGS_RST = 16'h0000;
    localparam logic [9:0]  DCWM_PARAM_RST = 10'h000;
    // ----------------------------------------
    // control word fields
    // ----------------------------------------
    localparam int DCWM_B_ENABLE   = 0;
    localparam int DCWM_B_RUN_FWD  = 1;
    localparam int DCWM_B_JOG      = 2;
    localparam int DCWM_B_RUN_REV  = 3;
    localparam int DCWM_B_FWD_REV  = 4;
    localparam int DCWM_B_RUN      = 5;
    localparam int DCWM_B_NOT_STOP = 6;
    localparam int DCWM_B_AUTO     = 7;
    localparam int DCWM_B_REF_SEL  = 8;
    localparam int DCWM_B_JOG_REV  = 9;
    localparam int DCWM_B_TRIP     = 12;
    localparam int DCWM_B_RESET    = 13;
    localparam int DCWM_B_WDOG     = 14;
    localparam logic [14:0] DCWM_CWORD_MASK = 15'h73FF;
    // event flag bits
    localparam int DCWM_F_DEFAULTS = 0;
    localparam int DCWM_F_MODE     = 1;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int DCWM_CLK_MHZ     = 100;
    localparam int DCWM_SCAN_US     = 4000;
    localparam int DCWM_SCAN_CYC    = DCWM_SCAN_US * DCWM_CLK_MHZ;
    localparam int DCWM_WDOG_MS     = 1000;
    localparam int DCWM_WDOG_CYC    = DCWM_WDOG_MS * 1000 * DCWM_CLK_MHZ;
endpackage : dcwm_pkg
`default_nettype wire

// file: dcwm_wdog.sv
// Purpose: comms watchdog for the control word mapper
// Assumes: service is a one-cycle pulse on pclk
// Notes:   disarms itself when it expires
`default_nettype none
module dcwm_wdog
    import dcwm_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = DCWM_WDOG_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic service,
    // status
    output logic      armed,
    output logic      expire
);
    logic [31:0] cnt_reg;
    logic        armed_reg;
    logic        expire_reg;
    wire logic   at_end = armed_reg && (cnt_reg >= TIMEOUT_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg    <= 32'h0000_0000;
            armed_reg  <= 1'b0;
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= !service && at_end;
            if (service) begin
                armed_reg <= 1'b1;
                cnt_reg   <= 32'h0000_0000;
            end else if (at_end) begin
                armed_reg <= 1'b0;
                cnt_reg   <= 32'h0000_0000;
            end else if (armed_reg) begin
                cnt_reg   <= cnt_reg + 32'h0000_0001;
            end
        end
    end
    assign armed  = armed_reg;
    assign expire = expire_reg;

    chk_wdog_disarm: assert property (@(posedge pclk) disable iff (!presetn)
        expire |-> !armed_reg) else $error("watchdog still armed after expiry");
endmodule // dcwm_wdog
`default_nettype wire

// file: drive_control_word_mapper_tb.sv
// Purpose: self-checking bench for the drive control word mapper
// Assumes: shortened counts, watchdog 200 cycles, scan 16 cycles
// Notes:   table rows cover gating and override selection
`default_nettype none
module drive_control_word_mapper_tb
    import dcwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        defaults_saved, mode_change_saved;
    logic        seq_drive_enable, seq_run_forward, seq_jog, seq_run_reverse;
    logic        seq_direction_select, seq_run, seq_not_stop, seq_jog_reverse;
    logic        reference_select, control_word_trip, comms_loss_trip;
    logic        drive_reset_pulse, scan_tick;
    int          miscompares = 0;
    int          checked = 0;
    int          pulses = 0;
    wire logic [9:0] seq_vec = {seq_jog_reverse, reference_select, 1'b0, seq_not_stop,
        seq_run, seq_direction_select, seq_run_reverse, seq_jog, seq_run_forward,
        seq_drive_enable};

    // gate, control word, parameters, expected outputs in control word layout
    localparam logic [35:0] ROWS [6] = '{
        {1'b0, 15'h03FF, 10'h000, 10'h000},
        {1'b1, 15'h007F, 10'h000, 10'h000},
        {1'b1, 15'h03FF, 10'h000, 10'h37F},
        {1'b1, 15'h0180, 10'h27F, 10'h100},
        {1'b0, 15'h0000, 10'h2A5, 10'h225},
        {1'b1, 15'h0085, 10'h000, 10'h005}};

    dcwm_mapper #(.WDOG_CYC(200), .SCAN_CYC(16)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .defaults_saved(defaults_saved),
        .mode_change_saved(mode_change_saved), .seq_drive_enable(seq_drive_enable),
        .seq_run_forward(seq_run_forward), .seq_jog(seq_jog),
        .seq_run_reverse(seq_run_reverse), .seq_direction_select(seq_direction_select),
        .seq_run(seq_run), .seq_not_stop(seq_not_stop), .seq_jog_reverse(seq_jog_reverse),
        .reference_select(reference_select), .control_word_trip(control_word_trip),
        .comms_loss_trip(comms_loss_trip), .drive_reset_pulse(drive_reset_pulse),
        .scan_tick(scan_tick), .irq(irq));

    dcwm_host_model u_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

    // ----------------------------------------
    // clock, pulse counter, helpers
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (drive_reset_pulse === 1'b1) pulses <= pulses + 1;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic wait_scan();
        int ticks;
        ticks = 0;
        for (int n = 0; n < 100 && ticks < 2; n++) begin
            @(posedge pclk);
            if (scan_tick === 1'b1) ticks++;
        end
        settle(1);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        logic        g;
        logic [14:0] cw;
        logic [9:0]  pm, ex;
        presetn = 1'b0;
        defaults_saved = 1'b0;
        mode_change_saved = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        u_host.rd(DCWM_OFF_FLAGS, q);
        chk("flags_reset", q, 32'h0000_0000);
        u_host.rd(DCWM_OFF_CWORD, q);
        chk("cword_reset", q, 32'h0000_0000);
        u_host.rd(DCWM_OFF_GATE, q);
        chk("gate_reset", q, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            {g, cw, pm, ex} = ROWS[i];
            u_host.wr(DCWM_OFF_PARAM, {22'h00_0000, pm});
            u_host.write_cword(cw);
            u_host.wr(DCWM_OFF_GATE, {31'h0000_0000, g});
            wait_scan();
            chk("seq_outputs", {22'h00_0000, seq_vec}, {22'h00_0000, ex});
        end
        q = 32'h0000_0000;
        do @(posedge pclk); while (scan_tick !== 1'b1);
        do begin
            @(posedge pclk);
            q = q + 32'h0000_0001;
        end while (scan_tick !== 1'b1);
        chk("scan_period", q, 32'h0000_0010);
        u_host.wr(DCWM_OFF_GATE, 32'h0000_0000);
        u_host.wr(DCWM_OFF_CWORD, 32'h0000_7FFF);
        u_host.rd(DCWM_OFF_CWORD, q);
        chk("cword_reserved", q, 32'h0000_73FF);
        settle(3);
        chk("trip_gate_closed", 32'(control_word_trip), 32'h0000_0000);
        chk("reset_gate_closed", 32'(pulses), 32'h0000_0000);
        u_host.write_cword(15'h0000);
        u_host.wr(DCWM_OFF_GATE, 32'h0000_0001);
        u_host.write_cword(15'h1000);
        settle(2);
        chk("trip_set", 32'(control_word_trip), 32'h0000_0001);
        u_host.write_cword(15'h3000);
        settle(2);
        chk("trip_held", 32'(control_word_trip), 32'h0000_0001);
        chk("reset_pulses", 32'(pulses), 32'h0000_0001);
        u_host.rd(DCWM_OFF_PARAM, q);
        chk("param_kept", q, {22'h00_0000, pm});
        u_host.write_cword(15'h0000);
        settle(2);
        chk("trip_cleared", 32'(control_word_trip), 32'h0000_0000);
        u_host.service_wdog(15'h0000);
        repeat (150) @(posedge pclk);
        u_host.service_wdog(15'h0000);
        settle(150);
        chk("wdog_serviced", 32'(comms_loss_trip), 32'h0000_0000);
        settle(60);
        chk("wdog_expired", 32'(comms_loss_trip), 32'h0000_0001);
        u_host.rd(DCWM_OFF_STAT, q);
        chk("wdog_disarmed", 32'(q[5]), 32'h0000_0000);
        u_host.write_cword(15'h6000);
        settle(2);
        chk("loss_trip_reset", 32'(comms_loss_trip), 32'h0000_0000);
        u_host.wr(DCWM_OFF_IRQ_CL, 32'h0000_000F);
        u_host.wr(DCWM_OFF_IRQ_EN, 32'h0000_0003);
        defaults_saved <= 1'b1;
        settle(6);
        chk("irq_defaults", 32'(irq), 32'h0000_0001);
        u_host.rd(DCWM_OFF_FLAGS, q);
        chk("flag_defaults", q, 32'h0000_0001);
        u_host.rd(DCWM_OFF_IRQ_ST, q);
        chk("irq_status", q, 32'h0000_0001);
        defaults_saved <= 1'b0;
        u_host.wr(DCWM_OFF_FLAGS, 32'h0000_0000);
        u_host.wr(DCWM_OFF_IRQ_CL, 32'h0000_0001);
        settle(1);
        chk("irq_cleared", 32'(irq), 32'h0000_0000);
        u_host.rd(DCWM_OFF_FLAGS, q);
        chk("flag_sticky", q, 32'h0000_0001);
        mode_change_saved <= 1'b1;
        settle(6);
        u_host.rd(DCWM_OFF_FLAGS, q);
        chk("flag_mode", q, 32'h0000_0003);
        u_host.wr(DCWM_OFF_IRQ_EN, 32'h0000_0000);
        settle(1);
        chk("irq_masked", 32'(irq), 32'h0000_0000);
        u_host.wr(DCWM_OFF_IRQ_EN, 32'h0000_0002);
        settle(1);
        chk("irq_mode", 32'(irq), 32'h0000_0001);
        u_host.rd(8'h40, q);
        chk("unmapped_data", q, 32'h0000_0000);
        chk("unmapped_err", 32'(u_host.last_err), 32'h0000_0001);
        presetn <= 1'b0;
        mode_change_saved <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        u_host.rd(DCWM_OFF_FLAGS, q);
        chk("flags_power_up", q, 32'h0000_0000);
        test_done();
    end
endmodule // drive_control_word_mapper_tb
`default_nettype wire
